// ===== rtl/hps_pkg.sv
package hps_pkg;

  localparam int unsigned HPS_CMD_W = 8;
  localparam int unsigned HPS_SYNC_STAGES = 2;

  localparam logic HPS_LED_OFF = 1'h1;
  localparam logic HPS_LED_ON = 1'h0;
  localparam logic HPS_VIO_1V5 = 1'h0;

  // Pin levels after the two-flop synchroniser.
  typedef struct packed {
    logic supplies_valid;
    logic direct_mode_select;
    logic main_power_enable_in;
    logic aux_switch_in;
    logic attention_button_in;
    logic attention_led_enable_in;
    logic power_led_enable_in;
    logic io_voltage_select;
    logic gate_drive_12v;
    logic gate_drive_5v_3v;
    logic main_below_threshold;
    logic main_overcurrent;
    logic aux_overcurrent;
    logic slot_clock_enable;
    logic slot_speed_mode_pin_in;
    logic serial_shift_clock;
    logic serial_latch_clock;
    logic serial_data_in;
  } hps_pins_s;

  // Idle levels loaded into the synchroniser at reset. Without them the active-low
  // pins would read as asserted for two edges after release and pulse aux power.
  localparam hps_pins_s HPS_PINS_IDLE = '{
    aux_switch_in: 1'h1,
    attention_button_in: 1'h1,
    main_below_threshold: 1'h1,
    default: 1'h0
  };

  // Command word moved from the shift register on a latch clock edge.
  // The first bit shifted in lands in the top field.
  typedef struct packed {
    logic main_power_req;
    logic attention_led_on;
    logic power_led_on;
    logic speed_66;
    logic vio_3v3;
    logic [2:0] spare;
  } hps_cmd_s;

  typedef enum logic [1:0] {
    HPS_PWR_OFF,
    HPS_PWR_RAMP_UP,
    HPS_PWR_ON,
    HPS_PWR_RAMP_DOWN
  } hps_pwr_e;

endpackage : hps_pkg

// ===== rtl/hps_shifter.sv
`timescale 1ns/10ps
`default_nettype none

module hps_shifter #(
  parameter int unsigned WIDTH = hps_pkg::HPS_CMD_W
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic shift_pulse,
  input wire logic latch_pulse,
  input wire logic data_in,
  output logic shift_out,
  output logic [WIDTH-1:0] par_out
);

  logic [WIDTH-1:0] shift_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      shift_reg <= '0;
      shift_out <= 1'h0;
    end else if (shift_pulse) begin
      shift_reg <= {shift_reg[WIDTH-2:0], data_in};
      shift_out <= shift_reg[WIDTH-1];
    end
  end

  // The parallel outputs change only on a latch edge, so a half-shifted word never acts.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      par_out <= '0;
    end else if (latch_pulse) begin
      par_out <= shift_reg;
    end
  end

endmodule : hps_shifter

`default_nettype wire

// ===== rtl/hps_slot_pins.sv
`timescale 1ns/10ps
`default_nettype none

module hps_slot_pins (
  input wire logic clock,
  input wire logic nrst,
  input wire logic supplies_valid,
  input wire logic direct_mode_select,
  input wire logic main_power_enable_in,
  input wire logic aux_switch_in,
  input wire logic attention_button_in,
  input wire logic attention_led_enable_in,
  input wire logic power_led_enable_in,
  input wire logic io_voltage_select,
  input wire logic gate_drive_12v,
  input wire logic gate_drive_5v_3v,
  input wire logic main_below_threshold,
  input wire logic main_overcurrent,
  input wire logic aux_overcurrent,
  input wire logic slot_clock_enable,
  input wire logic slot_speed_mode_pin_in,
  input wire logic serial_shift_clock,
  input wire logic serial_latch_clock,
  input wire logic serial_data_in,
  input wire logic button_clear,
  output logic slot_off_status,
  output logic main_power_on,
  output logic aux_power_on,
  output logic main_aux_fault_out,
  output logic aux_fault_latch,
  output logic attention_led_out,
  output logic power_led_out,
  output logic chain_data_out,
  output logic slot_speed_mode_pin_out,
  output logic slot_speed_mode_pin_oe,
  output logic speed_mode_sensed,
  output logic io_voltage_3v3,
  output logic forced_enable,
  output logic serial_mode_active,
  output logic button_pressed
);

  hps_pkg::hps_pins_s pins_raw;
  hps_pkg::hps_pins_s p;
  hps_pkg::hps_cmd_s cmd;
  hps_pkg::hps_pwr_e state_reg;
  hps_pkg::hps_pwr_e state_next;
  logic [hps_pkg::HPS_CMD_W-1:0] cmd_bits;
  logic pg_q_reg;
  logic sclk_q_reg;
  logic lclk_q_reg;
  logic mode_valid_reg;
  logic mode_direct_reg;
  logic main_fault_reg;
  logic pg_rise;
  logic shift_pulse;
  logic latch_pulse;
  logic overcurrent;
  logic power_req;
  logic main_fault_set;
  logic main_fault_clr;
  logic aux_fault_set;
  logic attn_on;
  logic pled_on;

  assign pins_raw = {supplies_valid, direct_mode_select, main_power_enable_in, aux_switch_in,
    attention_button_in, attention_led_enable_in, power_led_enable_in, io_voltage_select,
    gate_drive_12v, gate_drive_5v_3v, main_below_threshold, main_overcurrent, aux_overcurrent,
    slot_clock_enable, slot_speed_mode_pin_in, serial_shift_clock, serial_latch_clock,
    serial_data_in};

  hps_sync #(
    .WIDTH($bits(hps_pkg::hps_pins_s)),
    .RESET_VALUE(hps_pkg::HPS_PINS_IDLE)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d(pins_raw),
    .q(p)
  );

  // Data and clock share the synchroniser delay, so data is taken as it stood at the edge.
  hps_shifter #(
    .WIDTH(hps_pkg::HPS_CMD_W)
  ) u_shifter (
    .clock(clock),
    .nrst(nrst),
    .shift_pulse(shift_pulse),
    .latch_pulse(latch_pulse),
    .data_in(p.serial_data_in),
    .shift_out(chain_data_out),
    .par_out(cmd_bits)
  );

  assign cmd = hps_pkg::hps_cmd_s'(cmd_bits);
  assign pg_rise = p.supplies_valid & ~pg_q_reg;
  assign shift_pulse = p.serial_shift_clock & ~sclk_q_reg & ~mode_direct_reg;
  assign latch_pulse = p.serial_latch_clock & ~lclk_q_reg & ~mode_direct_reg;
  assign overcurrent = p.main_overcurrent | p.aux_overcurrent;
  assign power_req = mode_valid_reg & ~main_fault_reg & (forced_enable |
    (mode_direct_reg ? p.main_power_enable_in : cmd.main_power_req));
  assign main_fault_set = (state_reg == hps_pkg::HPS_PWR_ON) & overcurrent;
  assign main_fault_clr = mode_direct_reg ? ~p.main_power_enable_in : ~cmd.main_power_req;
  assign aux_fault_set = aux_power_on & p.aux_overcurrent;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pg_q_reg <= 1'h0;
      sclk_q_reg <= 1'h0;
      lclk_q_reg <= 1'h0;
    end else begin
      pg_q_reg <= p.supplies_valid;
      sclk_q_reg <= p.serial_shift_clock;
      lclk_q_reg <= p.serial_latch_clock;
    end
  end

  // Operating mode is only meaningful once the supplies have come good.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode_valid_reg <= 1'h0;
      mode_direct_reg <= 1'h0;
      forced_enable <= 1'h0;
      serial_mode_active <= 1'h0;
    end else if (pg_rise) begin
      mode_valid_reg <= 1'h1;
      mode_direct_reg <= p.direct_mode_select;
      forced_enable <= (power_led_out == hps_pkg::HPS_LED_ON);
      serial_mode_active <= ~p.direct_mode_select;
    end else if (!p.supplies_valid) begin
      mode_valid_reg <= 1'h0;
      forced_enable <= 1'h0;
      serial_mode_active <= 1'h0;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      hps_pkg::HPS_PWR_OFF: begin
        if (power_req) begin
          state_next = hps_pkg::HPS_PWR_RAMP_UP;
        end
      end
      hps_pkg::HPS_PWR_RAMP_UP: begin
        if (!power_req) begin
          state_next = hps_pkg::HPS_PWR_RAMP_DOWN;
        end else if (p.gate_drive_12v && p.gate_drive_5v_3v) begin
          state_next = hps_pkg::HPS_PWR_ON;
        end
      end
      hps_pkg::HPS_PWR_ON: begin
        if (overcurrent || !power_req) begin
          state_next = hps_pkg::HPS_PWR_RAMP_DOWN;
        end
      end
      hps_pkg::HPS_PWR_RAMP_DOWN: begin
        if (p.main_below_threshold) begin
          state_next = hps_pkg::HPS_PWR_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= hps_pkg::HPS_PWR_OFF;
      main_power_on <= 1'h0;
    end else begin
      state_reg <= state_next;
      main_power_on <= (state_next == hps_pkg::HPS_PWR_RAMP_UP) ||
        (state_next == hps_pkg::HPS_PWR_ON);
    end
  end

  // A plain disable holds the status high; only a fault or empty rails pull it low.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      slot_off_status <= 1'h0;
    end else if (main_fault_set) begin
      slot_off_status <= 1'h0;
    end else if (state_reg == hps_pkg::HPS_PWR_RAMP_DOWN && p.main_below_threshold) begin
      slot_off_status <= 1'h0;
    end else if (state_reg == hps_pkg::HPS_PWR_RAMP_UP && state_next == hps_pkg::HPS_PWR_ON) begin
      slot_off_status <= 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      main_fault_reg <= 1'h0;
    end else if (main_fault_set) begin
      main_fault_reg <= 1'h1;
    end else if (main_fault_clr) begin
      main_fault_reg <= 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      aux_fault_latch <= 1'h0;
      aux_power_on <= 1'h0;
    end else begin
      if (aux_fault_set) begin
        aux_fault_latch <= 1'h1;
      end else if (p.aux_switch_in) begin
        aux_fault_latch <= 1'h0;
      end
      aux_power_on <= ~p.aux_switch_in & ~aux_fault_set & ~aux_fault_latch;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      main_aux_fault_out <= 1'h0;
    end else begin
      main_aux_fault_out <= p.supplies_valid & (main_fault_reg | aux_fault_latch);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      button_pressed <= 1'h0;
    end else if (serial_mode_active && !p.attention_button_in) begin
      button_pressed <= 1'h1;
    end else if (button_clear) begin
      button_pressed <= 1'h0;
    end
  end

  // The serial command word resets to all zero, so both LEDs start off.
  always_comb begin
    attn_on = aux_fault_latch;
    if (p.supplies_valid && mode_valid_reg) begin
      attn_on = mode_direct_reg ? p.attention_led_enable_in : cmd.attention_led_on;
    end else if (p.supplies_valid) begin
      attn_on = 1'h0;
    end
    // The direct input leads before the mode is known, so forced mode can be strapped.
    pled_on = p.power_led_enable_in;
    if (mode_valid_reg) begin
      pled_on = mode_direct_reg ? p.power_led_enable_in : cmd.power_led_on;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      attention_led_out <= hps_pkg::HPS_LED_OFF;
      power_led_out <= hps_pkg::HPS_LED_OFF;
    end else begin
      attention_led_out <= attn_on ? hps_pkg::HPS_LED_ON : hps_pkg::HPS_LED_OFF;
      power_led_out <= pled_on ? hps_pkg::HPS_LED_ON : hps_pkg::HPS_LED_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      slot_speed_mode_pin_out <= 1'h0;
      slot_speed_mode_pin_oe <= 1'h0;
      speed_mode_sensed <= 1'h0;
    end else begin
      slot_speed_mode_pin_out <= 1'h0;
      slot_speed_mode_pin_oe <= serial_mode_active & p.slot_clock_enable & ~cmd.speed_66;
      speed_mode_sensed <= p.slot_speed_mode_pin_in;
    end
  end

  // The selection is only taken with the slot unpowered, so a late change
  // of the select input cannot swap rails under a live card.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      io_voltage_3v3 <= hps_pkg::HPS_VIO_1V5;
    end else if (state_reg == hps_pkg::HPS_PWR_OFF && mode_valid_reg) begin
      io_voltage_3v3 <= mode_direct_reg ? p.io_voltage_select : cmd.vio_3v3;
    end
  end

  mode_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !pg_rise |=> mode_direct_reg == $past(mode_direct_reg))
    else $error("operating mode changed without a supplies-valid rise");
  gates_before_on_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(slot_off_status) |-> $past(p.gate_drive_12v && p.gate_drive_5v_3v))
    else $error("slot status rose before both gate drives were high");
  fault_drop_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == hps_pkg::HPS_PWR_ON && overcurrent) |=> !slot_off_status && main_fault_reg)
    else $error("over-current did not drop slot status");
  off_after_low_a: assert property (@(posedge clock) disable iff (!nrst)
    $fell(slot_off_status) |-> $past(main_fault_set || p.main_below_threshold))
    else $error("slot status fell before rails were low");
  button_set_a: assert property (@(posedge clock) disable iff (!nrst)
    (serial_mode_active && !p.attention_button_in) |=> button_pressed)
    else $error("button press was not recorded");
  power_on_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == hps_pkg::HPS_PWR_OFF && power_req) |=> main_power_on ##0
    state_reg == hps_pkg::HPS_PWR_RAMP_UP)
    else $error("main power did not start on request");
  fault_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (mode_direct_reg && !p.main_power_enable_in && !main_fault_set) |=> !main_fault_reg)
    else $error("fault latch not cleared by enable deassertion");
  aux_follow_a: assert property (@(posedge clock) disable iff (!nrst)
    aux_power_on |-> $past(!p.aux_switch_in && !aux_fault_latch))
    else $error("aux power on without switch request");
  aux_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    (p.aux_switch_in && !aux_fault_set) |=> !aux_fault_latch)
    else $error("aux fault latch not cleared by switch");
  attn_fault_a: assert property (@(posedge clock) disable iff (!nrst)
    !p.supplies_valid |=> attention_led_out == !$past(aux_fault_latch))
    else $error("attention LED does not show aux fault latch");
  forced_mode_a: assert property (@(posedge clock) disable iff (!nrst)
    pg_rise |=> forced_enable == ($past(power_led_out) == hps_pkg::HPS_LED_ON))
    else $error("forced enable not taken from power LED");
  vio_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg != hps_pkg::HPS_PWR_OFF) |=> $stable(io_voltage_3v3))
    else $error("I/O voltage changed while slot powered");

endmodule : hps_slot_pins

`default_nettype wire

// ===== rtl/hps_sync.sv
`timescale 1ns/10ps
`default_nettype none

module hps_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_reg <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : hps_sync

`default_nettype wire

// ===== sim/hps_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

// Controller side of the serial link: one frame is eight bits, first bit
// first, then a latch clock pulse. The shift clock stands still between frames.
module hps_ctrl_model (
  input wire logic go,
  input wire logic [7:0] word,
  output logic serial_shift_clock,
  output logic serial_data_in,
  output logic serial_latch_clock,
  output logic done
);
  initial begin
    serial_shift_clock = 1'h0;
    serial_data_in = 1'h0;
    serial_latch_clock = 1'h0;
    done = 1'h1;
  end

  // Phase offset keeps the link edges 3 ns after the system clock rising edges.
  always @(posedge go) begin
    done = 1'h0;
    #3;
    for (int i = 7; i >= 0; i--) begin
      serial_data_in = word[i];
      #20 serial_shift_clock = 1'h1;
      #40 serial_shift_clock = 1'h0;
      #20;
    end
    // The line is released after the frame; show a changed level, not the last bit.
    serial_data_in = ~serial_data_in;
    #20 serial_latch_clock = 1'h1;
    #40 serial_latch_clock = 1'h0;
    #20 done = 1'h1;
  end
endmodule : hps_ctrl_model

`default_nettype wire

// ===== sim/hps_slot_pins_bench.sv
`timescale 1ns/10ps
`default_nettype none

module hps_slot_pins_bench;
  logic clock, nrst, supplies_valid, direct_mode_select, main_power_enable_in;
  logic aux_switch_in, attention_button_in, attention_led_enable_in, power_led_enable_in;
  logic io_voltage_select, gate_drive_12v, gate_drive_5v_3v, main_below_threshold;
  logic main_overcurrent, aux_overcurrent, slot_clock_enable, slot_speed_mode_pin_in;
  logic serial_shift_clock, serial_latch_clock, serial_data_in, button_clear;
  logic slot_off_status, main_power_on, aux_power_on, main_aux_fault_out, aux_fault_latch;
  logic attention_led_out, power_led_out, chain_data_out, slot_speed_mode_pin_out;
  logic slot_speed_mode_pin_oe, speed_mode_sensed, io_voltage_3v3, forced_enable;
  logic serial_mode_active, button_pressed, go, done;
  logic [7:0] word, wa, wb;
  logic [31:0] r;
  int num_errors, checked;

  // Speed pin has a pull-up; the device can only pull it low.
  assign slot_speed_mode_pin_in = slot_speed_mode_pin_oe ? slot_speed_mode_pin_out : 1'h1;

  hps_slot_pins DUT (.clock, .nrst, .supplies_valid, .direct_mode_select,
    .main_power_enable_in, .aux_switch_in, .attention_button_in, .attention_led_enable_in,
    .power_led_enable_in, .io_voltage_select, .gate_drive_12v, .gate_drive_5v_3v,
    .main_below_threshold, .main_overcurrent, .aux_overcurrent, .slot_clock_enable,
    .slot_speed_mode_pin_in, .serial_shift_clock, .serial_latch_clock, .serial_data_in,
    .button_clear, .slot_off_status, .main_power_on, .aux_power_on, .main_aux_fault_out,
    .aux_fault_latch, .attention_led_out, .power_led_out, .chain_data_out,
    .slot_speed_mode_pin_out, .slot_speed_mode_pin_oe, .speed_mode_sensed, .io_voltage_3v3,
    .forced_enable, .serial_mode_active, .button_pressed);

  hps_ctrl_model ctrl (.go, .word, .serial_shift_clock, .serial_data_in,
    .serial_latch_clock, .done);

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic seen, input logic exp, input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s seen %b expected %b", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Pin effects land within four edges, the speed pin loop within six; six just covers it.
  task automatic settle();
    repeat (6) @(posedge clock);
    #1;
  endtask : settle

  function automatic logic led(input logic on);
    return on ? hps_pkg::HPS_LED_ON : hps_pkg::HPS_LED_OFF;
  endfunction : led

  task automatic frame(input logic [7:0] w);
    @(posedge clock);
    word <= w;
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
    for (int i = 0; i < 300 && done !== 1'h1; i++) @(posedge clock);
    if (done !== 1'h1) begin
      num_errors++;
      $display("BAD %0t serial frame never ended", $time);
      wrap_up();
    end
    settle();
  endtask : frame

  initial begin
    num_errors = 0;
    checked = 0;
    {nrst, supplies_valid, main_power_enable_in, attention_led_enable_in} = 4'h0;
    {power_led_enable_in, io_voltage_select, gate_drive_12v, gate_drive_5v_3v} = 4'h0;
    {main_overcurrent, aux_overcurrent, slot_clock_enable, button_clear, go} = 5'h00;
    {direct_mode_select, aux_switch_in, attention_button_in, main_below_threshold} = 4'hF;
    word = 8'h00;
    r = $urandom(32'hCD1E);
    repeat (5) @(posedge clock);
    #1;
    chk(attention_led_out, 1'h1, "reset led");
    chk(power_led_out, 1'h1, "reset pled");
    chk(slot_off_status, 1'h0, "reset status");
    @(posedge clock);
    nrst <= 1'h1;
    supplies_valid <= 1'h1;
    settle();
    chk(serial_mode_active, 1'h0, "direct mode");
    chk(forced_enable, 1'h0, "no forced");
    for (int k = 0; k < 6; k++) begin
      r = $urandom();
      @(posedge clock);
      attention_led_enable_in <= r[0];
      power_led_enable_in <= r[1];
      io_voltage_select <= r[2];
      settle();
      chk(attention_led_out, led(r[0]), "atten led");
      chk(power_led_out, led(r[1]), "power led");
      chk(io_voltage_3v3, r[2], "vio");
    end
    @(posedge clock);
    main_power_enable_in <= 1'h1;
    main_below_threshold <= 1'h0;
    settle();
    chk(main_power_on, 1'h1, "main on");
    chk(slot_off_status, 1'h0, "ramping");
    @(posedge clock);
    gate_drive_12v <= 1'h1;
    settle();
    chk(slot_off_status, 1'h0, "one gate");
    @(posedge clock);
    gate_drive_5v_3v <= 1'h1;
    settle();
    chk(slot_off_status, 1'h1, "powered");
    @(posedge clock);
    main_power_enable_in <= 1'h0;
    settle();
    chk(slot_off_status, 1'h1, "rails up");
    @(posedge clock);
    {gate_drive_12v, gate_drive_5v_3v, main_below_threshold} <= 3'h1;
    settle();
    chk(slot_off_status, 1'h0, "rails low");
    chk(main_power_on, 1'h0, "main off");
    @(posedge clock);
    main_power_enable_in <= 1'h1;
    {gate_drive_12v, gate_drive_5v_3v, main_below_threshold} <= 3'h6;
    settle();
    @(posedge clock);
    main_overcurrent <= 1'h1;
    settle();
    chk(slot_off_status, 1'h0, "overcurrent");
    chk(main_aux_fault_out, 1'h1, "fault set");
    @(posedge clock);
    main_overcurrent <= 1'h0;
    {gate_drive_12v, gate_drive_5v_3v, main_below_threshold} <= 3'h1;
    settle();
    chk(main_aux_fault_out, 1'h1, "fault held");
    @(posedge clock);
    main_power_enable_in <= 1'h0;
    settle();
    chk(main_aux_fault_out, 1'h0, "fault cleared");
    @(posedge clock);
    aux_switch_in <= 1'h0;
    settle();
    chk(aux_power_on, 1'h1, "aux on");
    @(posedge clock);
    aux_overcurrent <= 1'h1;
    settle();
    @(posedge clock);
    aux_overcurrent <= 1'h0;
    supplies_valid <= 1'h0;
    settle();
    chk(aux_fault_latch, 1'h1, "aux held");
    chk(attention_led_out, hps_pkg::HPS_LED_ON, "aux fault led");
    @(posedge clock);
    aux_switch_in <= 1'h1;
    power_led_enable_in <= 1'h0;
    settle();
    chk(aux_fault_latch, 1'h0, "aux cleared");
    chk(attention_led_out, hps_pkg::HPS_LED_OFF, "no fault led");
    @(posedge clock);
    {direct_mode_select, power_led_enable_in, attention_led_enable_in} <= 3'h0;
    supplies_valid <= 1'h1;
    settle();
    chk(serial_mode_active, 1'h1, "serial mode");
    chk(attention_led_out, hps_pkg::HPS_LED_OFF, "serial led");
    chk(power_led_out, hps_pkg::HPS_LED_OFF, "serial pled");
    chk(speed_mode_sensed, 1'h1, "speed sensed");
    chk(slot_speed_mode_pin_oe, 1'h0, "speed not driven");
    chk(forced_enable, 1'h0, "serial not forced");
    @(posedge clock);
    direct_mode_select <= 1'h1;
    attention_button_in <= 1'h0;
    slot_clock_enable <= 1'h1;
    settle();
    chk(slot_speed_mode_pin_oe, 1'h1, "speed driven");
    chk(serial_mode_active, 1'h1, "mode held");
    chk(button_pressed, 1'h1, "button");
    @(posedge clock);
    attention_button_in <= 1'h1;
    settle();
    chk(button_pressed, 1'h1, "button sticky");
    @(posedge clock);
    button_clear <= 1'h1;
    @(posedge clock);
    button_clear <= 1'h0;
    settle();
    chk(button_pressed, 1'h0, "button clear");
    wa = 8'($urandom());
    wb = 8'($urandom());
    frame(wa);
    frame(wb);
    chk(chain_data_out, wa[0], "chain");
    chk(main_power_on, wb[7], "serial power");
    chk(attention_led_out, led(wb[6]), "serial atten");
    chk(power_led_out, led(wb[5]), "serial pled cmd");
    chk(slot_speed_mode_pin_oe, ~wb[4], "speed drive");
    chk(speed_mode_sensed, wb[4], "speed wire");
    chk(io_voltage_3v3, (wa[7] && wb[7]) ? wa[3] : wb[3], "serial vio");
    @(posedge clock);
    supplies_valid <= 1'h0;
    power_led_enable_in <= 1'h1;
    settle();
    @(posedge clock);
    supplies_valid <= 1'h1;
    settle();
    chk(forced_enable, 1'h1, "forced");
    wrap_up();
  end
endmodule : hps_slot_pins_bench

`default_nettype wire
